// file: src/ppb_host.sv
// Host end: grant driver and initiator of single or burst transfers.
`timescale 1ns/1ps
module ppb_host
  import ppb_pkg::*;
#(
  parameter int BURST_W = 4
)
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  ppb_bus_if.host bus,
  input wire logic grant_i,
  input wire logic start_i,
  input wire logic write_i,
  input wire logic dual_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] be_n_i,
  input wire logic [BURST_W-1:0] len_i,
  output logic busy_o,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic par_err_o
);
  if (BURST_W < 1 || BURST_W > 16) begin : bad_burst_w
    $error("BURST_W out of range");
  end

  ppb_state_e state_reg, state_next;
  logic [BURST_W-1:0] left_reg, left_next;
  logic wr_reg, wr_next;
  logic [31:0] ad_reg, ad_next;
  logic [3:0] cbe_reg, cbe_next;
  logic ad_oe_reg, ad_oe_next;
  logic par_reg, par_next;
  logic par_oe_reg, par_oe_next;
  logic frame_n_reg, frame_n_next;
  logic frame_oe_reg, frame_oe_next;
  logic irdy_n_reg, irdy_n_next;
  logic irdy_oe_reg, irdy_oe_next;
  logic [31:0] rd_reg, rd_next;
  logic rv_reg, rv_next;
  logic chk_reg, chk_next;
  logic [31:0] chk_ad_reg, chk_ad_next;
  logic perr_reg, perr_next;
  logic [3:0] cbe_cmd;
  logic done;

  assign cbe_cmd = {3'h3, write_i};
  assign done = !bus.primary_target_ready_n && !irdy_n_reg;

  always_comb begin
    state_next = state_reg;
    left_next = left_reg;
    wr_next = wr_reg;
    ad_next = ad_reg;
    cbe_next = cbe_reg;
    ad_oe_next = 1'b0;
    par_next = ppb_parity(ad_reg, cbe_reg);
    par_oe_next = ad_oe_reg;
    frame_n_next = 1'b1;
    frame_oe_next = 1'b0;
    irdy_n_next = 1'b1;
    irdy_oe_next = 1'b0;
    rd_next = rd_reg;
    rv_next = 1'b0;
    chk_next = 1'b0;
    chk_ad_next = bus.ad;
    perr_next = chk_reg && (ppb_parity(chk_ad_reg, be_n_i) != bus.primary_parity);
    unique case (state_reg)
      PPB_IDLE: begin
        if (start_i && grant_i && bus.frame_n && bus.primary_initiator_ready_n) begin
          wr_next = write_i;
          left_next = len_i;
          ad_next = addr_i;
          cbe_next = dual_i ? PPB_CMD_DUAL_ADDR : cbe_cmd;
          ad_oe_next = 1'b1;
          frame_n_next = 1'b0;
          frame_oe_next = 1'b1;
          state_next = dual_i ? PPB_ADDR2 : PPB_ADDR;
        end
      end
      PPB_ADDR2: begin
        cbe_next = cbe_cmd;
        ad_oe_next = 1'b1;
        frame_n_next = 1'b0;
        frame_oe_next = 1'b1;
        state_next = PPB_ADDR;
      end
      PPB_ADDR, PPB_DATA: begin
        cbe_next = be_n_i;
        ad_next = wdata_i;
        ad_oe_next = wr_reg;
        irdy_n_next = 1'b0;
        irdy_oe_next = 1'b1;
        frame_oe_next = 1'b1;
        frame_n_next = (left_reg == '0);
        state_next = PPB_DATA;
        if (state_reg == PPB_DATA && done) begin
          chk_next = !wr_reg;
          rd_next = bus.ad;
          rv_next = !wr_reg;
          if (left_reg == '0) begin
            ad_oe_next = 1'b0;
            irdy_n_next = 1'b1;
            frame_oe_next = 1'b0;
            state_next = PPB_TURN;
          end else begin
            left_next = left_reg - 1'b1;
            frame_n_next = (left_reg == BURST_W'(1));
          end
        end
      end
      PPB_TURN: begin
        state_next = PPB_IDLE;
      end
      default: state_next = PPB_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg <= PPB_IDLE;
      left_reg <= '0;
      wr_reg <= 1'b0;
      ad_reg <= 32'h0000_0000;
      cbe_reg <= 4'hF;
      ad_oe_reg <= 1'b0;
      par_reg <= 1'b0;
      par_oe_reg <= 1'b0;
      frame_n_reg <= 1'b1;
      frame_oe_reg <= 1'b0;
      irdy_n_reg <= 1'b1;
      irdy_oe_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
      rv_reg <= 1'b0;
      chk_reg <= 1'b0;
      chk_ad_reg <= 32'h0000_0000;
      perr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      left_reg <= left_next;
      wr_reg <= wr_next;
      ad_reg <= ad_next;
      cbe_reg <= cbe_next;
      ad_oe_reg <= ad_oe_next;
      par_reg <= par_next;
      par_oe_reg <= par_oe_next;
      frame_n_reg <= frame_n_next;
      frame_oe_reg <= frame_oe_next;
      irdy_n_reg <= irdy_n_next;
      irdy_oe_reg <= irdy_oe_next;
      rd_reg <= rd_next;
      rv_reg <= rv_next;
      chk_reg <= chk_next;
      chk_ad_reg <= chk_ad_next;
      perr_reg <= perr_next;
    end
  end

  // Frame and irdy stay driven high for the turnaround clock.
  assign bus.host_frame_n_o = frame_n_reg;
  assign bus.host_frame_oe = frame_oe_reg || (state_reg == PPB_TURN);
  assign bus.host_irdy_n_o = irdy_n_reg;
  assign bus.host_irdy_oe = irdy_oe_reg || (state_reg == PPB_TURN);
  assign bus.host_ad_o = ad_reg;
  assign bus.host_ad_oe = ad_oe_reg;
  assign bus.host_cbe_o = cbe_reg;
  assign bus.host_cbe_oe = (state_reg != PPB_IDLE) && (state_reg != PPB_TURN);
  assign bus.host_par_o = par_reg;
  assign bus.host_par_oe = par_oe_reg;
  // The grant is withdrawn while a start is pending, so the bridge stops parking before our address.
  assign bus.host_gnt_n_o = !(grant_i && !start_i && state_reg == PPB_IDLE);
  assign busy_o = (state_reg != PPB_IDLE);
  assign rdata_o = rd_reg;
  assign rvalid_o = rv_reg;
  assign par_err_o = perr_reg;
endmodule

// file: inc/ppb_pkg.sv
// Shared constants, the state type and the parity helper function for the primary bus ends.
package ppb_pkg;
  localparam int PPB_AD_W = 32;
  localparam int PPB_CBE_W = 4;
  localparam logic [3:0] PPB_CMD_DUAL_ADDR = 4'hD;
  localparam logic [31:0] PPB_PARK_AD = 32'h0000_0000;
  localparam logic [3:0] PPB_PARK_CBE = 4'h0;
  localparam logic [3:0] PPB_BE_ALL_N = 4'h0;
  localparam int PPB_RESET_CYCLES = 1;

  typedef enum logic [2:0] {
    PPB_IDLE = 3'b000,
    PPB_ADDR = 3'b001,
    PPB_ADDR2 = 3'b010,
    PPB_DATA = 3'b011,
    PPB_TURN = 3'b100
  } ppb_state_e;

  // Even parity over the 36 covered bits.
  function automatic logic ppb_parity(input logic [31:0] ad, input logic [3:0] cbe);
    ppb_parity = ^{ad, cbe};
  endfunction
endpackage

// file: inc/ppb_bus_if.sv
// Interface joining the bridge primary end and the host end, with resolved wires.
`timescale 1ns/1ps
interface ppb_bus_if;
  logic [31:0] dev_ad_o;
  logic [31:0] dev_ad_oe;
  logic [3:0] dev_cbe_o;
  logic dev_cbe_oe;
  logic dev_par_o;
  logic dev_par_oe;
  logic dev_trdy_n_o;
  logic dev_trdy_oe;
  logic host_frame_n_o;
  logic host_frame_oe;
  logic host_irdy_n_o;
  logic host_irdy_oe;
  logic [31:0] host_ad_o;
  logic host_ad_oe;
  logic [3:0] host_cbe_o;
  logic host_cbe_oe;
  logic host_par_o;
  logic host_par_oe;
  logic host_gnt_n_o;
  logic [31:0] ad;
  logic [3:0] primary_cmd_byte_en_n;
  logic primary_parity;
  logic frame_n;
  logic primary_initiator_ready_n;
  logic primary_target_ready_n;

  // Active-low control lines float high through the pull-up.
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      ad[i] = dev_ad_oe[i] ? dev_ad_o[i] : (host_ad_oe ? host_ad_o[i] : 1'b1);
    end
    primary_cmd_byte_en_n = dev_cbe_oe ? dev_cbe_o : (host_cbe_oe ? host_cbe_o : 4'hF);
    primary_parity = dev_par_oe ? dev_par_o : (host_par_oe ? host_par_o : 1'b1);
    frame_n = host_frame_oe ? host_frame_n_o : 1'b1;
    primary_initiator_ready_n = host_irdy_oe ? host_irdy_n_o : 1'b1;
    primary_target_ready_n = dev_trdy_oe ? dev_trdy_n_o : 1'b1;
  end

  modport dev (
    output dev_ad_o, dev_ad_oe, dev_cbe_o, dev_cbe_oe, dev_par_o, dev_par_oe,
    output dev_trdy_n_o, dev_trdy_oe,
    input ad, primary_cmd_byte_en_n, primary_parity, frame_n, primary_initiator_ready_n,
    input primary_target_ready_n, host_gnt_n_o
  );
  modport host (
    output host_frame_n_o, host_frame_oe, host_irdy_n_o, host_irdy_oe, host_ad_o, host_ad_oe,
    output host_cbe_o, host_cbe_oe, host_par_o, host_par_oe, host_gnt_n_o,
    input ad, primary_cmd_byte_en_n, primary_parity, frame_n, primary_initiator_ready_n,
    input primary_target_ready_n
  );
endinterface

// file: src/ppb_dev.sv
// Bridge primary end: target for host reads and writes, bus parking, parity.
// Functional notes
// - Drive released active-low lines high one clock.
// - Suffix _n means asserted low.
// - AD carries address, then write or read data.
// - Park AD and CBE when idle and granted.
// - Parity parks one clock after AD.
// - Dual-address command precedes real command.
// - Initiator drives byte enables every data phase.
// - Parity is even over 36 bits.
// - Parity comes from whoever drove the data.
// - Parity valid one clock after its data.
// - Parity released one clock after AD.
// - Receivers check parity against received bits.
// - Frame asserted while more data intended.
// - Frame deasserted marks final data phase.
// - Idle frame driven high once, then released.
// - Irdy holds until data phase completes.
// - Trdy holds until data phase completes.
`timescale 1ns/1ps
module ppb_dev
  import ppb_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  ppb_bus_if.dev bus,
  input wire logic [31:0] rd_data_i,
  output logic [31:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_be_n_o,
  output logic [3:0] cmd_o,
  output logic wr_valid_o,
  output logic par_err_o
);
  ppb_state_e state_reg, state_next;
  logic read_reg, read_next;
  logic [31:0] addr_reg, addr_next;
  logic [31:0] wdat_reg, wdat_next;
  logic [3:0] be_reg, be_next;
  logic [3:0] cmd_reg, cmd_next;
  logic wv_reg, wv_next;
  logic [31:0] ad_o_reg, ad_o_next;
  logic ad_oe_reg, ad_oe_next;
  logic cbe_oe_reg, cbe_oe_next;
  logic par_reg, par_next;
  logic par_oe_reg, par_oe_next;
  logic trdy_n_reg, trdy_n_next;
  logic trdy_oe_reg, trdy_oe_next;
  logic chk_reg, chk_next;
  logic [31:0] chk_ad_reg, chk_ad_next;
  logic [3:0] chk_cbe_reg, chk_cbe_next;
  logic perr_reg, perr_next;
  logic [31:0] waddr_reg, waddr_next;
  logic idle_gnt;
  logic phase_done;

  // Parking needs the bus idle (no frame, no irdy) and our grant.
  assign idle_gnt = !bus.host_gnt_n_o && bus.frame_n && bus.primary_initiator_ready_n;

  // A data phase completes on the clock where both ready lines are low.
  assign phase_done = !trdy_n_reg && !bus.primary_initiator_ready_n;

  // Bit 0 of a command tells a read (clear) from a write (set).
  function automatic logic cmd_is_read(input logic [3:0] cmd);
    cmd_is_read = !cmd[0];
  endfunction

  always_comb begin
    state_next = state_reg;
    read_next = read_reg;
    addr_next = addr_reg;
    wdat_next = wdat_reg;
    be_next = be_reg;
    cmd_next = cmd_reg;
    wv_next = 1'b0;
    waddr_next = waddr_reg;
    ad_o_next = ad_o_reg;
    ad_oe_next = 1'b0;
    cbe_oe_next = 1'b0;
    trdy_n_next = 1'b1;
    trdy_oe_next = 1'b0;
    chk_next = 1'b0;
    chk_ad_next = bus.ad;
    chk_cbe_next = bus.primary_cmd_byte_en_n;
    // Parity follows the AD driver by one clock in value and enable.
    par_next = ppb_parity(ad_o_reg, cbe_oe_reg ? PPB_PARK_CBE : bus.primary_cmd_byte_en_n);
    par_oe_next = ad_oe_reg;
    perr_next = 1'b0;
    // Received bits wait one clock here to meet the parity that follows them.
    if (chk_reg) begin
      perr_next = ppb_parity(chk_ad_reg, chk_cbe_reg) != bus.primary_parity;
    end
    unique case (state_reg)
      PPB_IDLE: begin
        // A falling frame in idle opens a transaction and its address is taken now.
        if (!bus.frame_n) begin
          addr_next = bus.ad;
          cmd_next = bus.primary_cmd_byte_en_n;
          read_next = cmd_is_read(bus.primary_cmd_byte_en_n);
          chk_next = 1'b1;
          state_next = (bus.primary_cmd_byte_en_n == PPB_CMD_DUAL_ADDR) ? PPB_ADDR2 : PPB_DATA;
        end else if (idle_gnt) begin
          // The host withdraws the grant before it starts, so parking never meets its address.
          ad_o_next = PPB_PARK_AD;
          ad_oe_next = 1'b1;
          cbe_oe_next = 1'b1;
        end
      end
      PPB_ADDR2: begin
        cmd_next = bus.primary_cmd_byte_en_n;
        read_next = cmd_is_read(bus.primary_cmd_byte_en_n);
        chk_next = 1'b1;
        state_next = PPB_DATA;
      end
      PPB_DATA: begin
        // Trdy comes two clocks after the address, which leaves a turnaround clock on reads.
        ad_oe_next = read_reg;
        ad_o_next = rd_data_i;
        trdy_n_next = 1'b0;
        trdy_oe_next = 1'b1;
        if (phase_done) begin
          chk_next = 1'b1;
          if (!read_reg) begin
            wdat_next = bus.ad;
            wv_next = 1'b1;
          end
          be_next = bus.primary_cmd_byte_en_n;
          // The phase's own address goes out with its data while addr_reg moves on.
          waddr_next = addr_reg;
          addr_next = addr_reg + 32'h0000_0004;
          if (bus.frame_n) begin
            ad_oe_next = 1'b0;
            trdy_n_next = 1'b1;
            state_next = PPB_TURN;
          end
        end
      end
      PPB_TURN: begin
        // Trdy is driven high here for one clock before the pull-up takes over.
        state_next = PPB_IDLE;
      end
      default: state_next = PPB_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg <= PPB_IDLE;
      read_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      wdat_reg <= 32'h0000_0000;
      be_reg <= 4'hF;
      cmd_reg <= 4'h0;
      wv_reg <= 1'b0;
      ad_o_reg <= 32'h0000_0000;
      ad_oe_reg <= 1'b0;
      cbe_oe_reg <= 1'b0;
      par_reg <= 1'b0;
      par_oe_reg <= 1'b0;
      trdy_n_reg <= 1'b1;
      trdy_oe_reg <= 1'b0;
      chk_reg <= 1'b0;
      chk_ad_reg <= 32'h0000_0000;
      chk_cbe_reg <= 4'h0;
      perr_reg <= 1'b0;
      waddr_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      read_reg <= read_next;
      addr_reg <= addr_next;
      wdat_reg <= wdat_next;
      be_reg <= be_next;
      cmd_reg <= cmd_next;
      wv_reg <= wv_next;
      ad_o_reg <= ad_o_next;
      ad_oe_reg <= ad_oe_next;
      cbe_oe_reg <= cbe_oe_next;
      par_reg <= par_next;
      par_oe_reg <= par_oe_next;
      trdy_n_reg <= trdy_n_next;
      trdy_oe_reg <= trdy_oe_next;
      chk_reg <= chk_next;
      chk_ad_reg <= chk_ad_next;
      chk_cbe_reg <= chk_cbe_next;
      perr_reg <= perr_next;
      waddr_reg <= waddr_next;
    end
  end

  assign bus.dev_ad_o = ad_o_reg;
  assign bus.dev_ad_oe = {32{ad_oe_reg}};
  // This end only ever drives the parked value on the byte enables.
  assign bus.dev_cbe_o = PPB_PARK_CBE;
  assign bus.dev_cbe_oe = cbe_oe_reg;
  assign bus.dev_par_o = par_reg;
  assign bus.dev_par_oe = par_oe_reg;
  // Trdy stays driven through the turnaround clock so it is released high.
  assign bus.dev_trdy_n_o = trdy_n_reg;
  assign bus.dev_trdy_oe = trdy_oe_reg || (state_reg == PPB_TURN);
  assign wr_addr_o = waddr_reg;
  assign wr_data_o = wdat_reg;
  assign wr_be_n_o = be_reg;
  assign cmd_o = cmd_reg;
  assign wr_valid_o = wv_reg;
  assign par_err_o = perr_reg;
endmodule

// file: tb/ppb_sva.sv
// Checker watching the wire-level protocol between the two primary bus ends.
`timescale 1ns/1ps
module ppb_sva
  import ppb_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [31:0] dev_ad_o,
  input wire logic [31:0] dev_ad_oe,
  input wire logic dev_cbe_oe,
  input wire logic dev_par_oe,
  input wire logic host_frame_n_o,
  input wire logic host_frame_oe,
  input wire logic host_irdy_n_o,
  input wire logic host_irdy_oe,
  input wire logic host_ad_oe,
  input wire logic host_cbe_oe,
  input wire logic host_par_oe,
  input wire logic host_gnt_n_o,
  input wire logic [31:0] ad,
  input wire logic [3:0] primary_cmd_byte_en_n,
  input wire logic primary_parity,
  input wire logic frame_n,
  input wire logic primary_initiator_ready_n,
  input wire logic primary_target_ready_n
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  logic idle;
  logic last_done;
  assign idle = frame_n && primary_initiator_ready_n && primary_target_ready_n;
  assign last_done = !primary_initiator_ready_n && !primary_target_ready_n && frame_n;

  parity_even_a: assert property (
    ((|$past(dev_ad_oe)) || $past(host_ad_oe)) && (dev_par_oe || host_par_oe)
    |-> primary_parity == ^{$past(ad), $past(primary_cmd_byte_en_n)})
    else $error("parity does not match the previous ad and cbe");
  host_par_rel_a: assert property ($fell(host_ad_oe) |-> host_par_oe ##1 !host_par_oe)
    else $error("host parity not released one clock after ad");
  dev_par_rel_a: assert property ($fell(dev_ad_oe[0]) |-> dev_par_oe ##1 !dev_par_oe)
    else $error("bridge parity not released one clock after ad");
  dev_par_follow_a: assert property ($rose(dev_ad_oe[0]) |-> !dev_par_oe ##1 dev_par_oe)
    else $error("bridge parity not driven one clock after ad");
  host_par_follow_a: assert property ($rose(host_ad_oe) |=> host_par_oe)
    else $error("host parity not driven one clock after ad");
  idle_park_a: assert property ((!host_gnt_n_o && idle)[*3]
    |-> (&dev_ad_oe) && dev_cbe_oe && dev_ad_o == PPB_PARK_AD)
    else $error("idle granted bus not parked");
  idle_float_a: assert property ((host_gnt_n_o && idle)[*3] |-> !(|dev_ad_oe) && !dev_cbe_oe)
    else $error("bridge drives an idle bus without grant");
  frame_start_a: assert property (
    $fell(frame_n) && primary_cmd_byte_en_n != PPB_CMD_DUAL_ADDR
    |-> host_ad_oe && host_cbe_oe ##1 !primary_initiator_ready_n)
    else $error("address phase not followed by initiator ready");
  dual_cmd_a: assert property (
    $fell(frame_n) && primary_cmd_byte_en_n == PPB_CMD_DUAL_ADDR
    |=> host_ad_oe && !frame_n && primary_cmd_byte_en_n != PPB_CMD_DUAL_ADDR)
    else $error("second address phase missing its command");
  be_drive_a: assert property (!primary_initiator_ready_n |-> host_cbe_oe)
    else $error("byte enables not driven in a data phase");
  irdy_hold_a: assert property (
    !primary_initiator_ready_n && primary_target_ready_n |=> !primary_initiator_ready_n)
    else $error("initiator ready dropped before completion");
  trdy_hold_a: assert property (
    !primary_target_ready_n && primary_initiator_ready_n |=> !primary_target_ready_n)
    else $error("target ready dropped before completion");
  frame_end_a: assert property (last_done |=> host_frame_oe && host_frame_n_o
    && host_irdy_oe && host_irdy_n_o ##1 !host_frame_oe && !host_irdy_oe)
    else $error("frame and irdy not driven high once after the last phase");
  read_data_a: assert property (
    !primary_target_ready_n && !host_ad_oe |-> (&dev_ad_oe) ##1 dev_par_oe)
    else $error("read data or its parity not driven by the bridge");
endmodule

// file: tb/tb.sv
// Testbench joining the bridge end and the host end across the bus interface.
`timescale 1ns/1ps
module tb;
  logic sys_clk_i, reset_i, grant_i, start_i, write_i, dual_i;
  logic busy_o, rvalid_o, wr_valid_o, dev_perr, host_perr;
  logic [31:0] addr_i, wdata_i, rd_data_i, rdata_o, wr_addr_o, wr_data_o;
  logic [3:0] be_n_i, len_i, wr_be_n_o, cmd_o;
  logic [31:0] seed = 32'hBFF1D171;
  logic [69:0] wq[$];
  logic [31:0] rq[$];
  logic [69:0] we, wg;
  int fail_count = 0;
  int checked = 0;

  ppb_bus_if i_ppb_bus_if();
  ppb_dev i_ppb_dev (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus(i_ppb_bus_if),
    .rd_data_i(rd_data_i), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .wr_be_n_o(wr_be_n_o), .cmd_o(cmd_o), .wr_valid_o(wr_valid_o), .par_err_o(dev_perr));
  ppb_host #(.BURST_W(4)) i_ppb_host (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .bus(i_ppb_bus_if), .grant_i(grant_i), .start_i(start_i), .write_i(write_i),
    .dual_i(dual_i), .addr_i(addr_i), .wdata_i(wdata_i), .be_n_i(be_n_i), .len_i(len_i),
    .busy_o(busy_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .par_err_o(host_perr));
  ppb_sva i_ppb_sva (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .dev_ad_o(i_ppb_bus_if.dev_ad_o), .dev_ad_oe(i_ppb_bus_if.dev_ad_oe),
    .dev_cbe_oe(i_ppb_bus_if.dev_cbe_oe), .dev_par_oe(i_ppb_bus_if.dev_par_oe),
    .host_frame_n_o(i_ppb_bus_if.host_frame_n_o), .host_frame_oe(i_ppb_bus_if.host_frame_oe),
    .host_irdy_n_o(i_ppb_bus_if.host_irdy_n_o), .host_irdy_oe(i_ppb_bus_if.host_irdy_oe),
    .host_ad_oe(i_ppb_bus_if.host_ad_oe), .host_cbe_oe(i_ppb_bus_if.host_cbe_oe),
    .host_par_oe(i_ppb_bus_if.host_par_oe), .host_gnt_n_o(i_ppb_bus_if.host_gnt_n_o),
    .ad(i_ppb_bus_if.ad), .primary_cmd_byte_en_n(i_ppb_bus_if.primary_cmd_byte_en_n),
    .primary_parity(i_ppb_bus_if.primary_parity), .frame_n(i_ppb_bus_if.frame_n),
    .primary_initiator_ready_n(i_ppb_bus_if.primary_initiator_ready_n),
    .primary_target_ready_n(i_ppb_bus_if.primary_target_ready_n));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic test_done();
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_wr(input string n, input logic [69:0] e, input logic [69:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_rd(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy_o !== v) begin
      @(posedge sys_clk_i);
      #1;
      n++;
      if (n > 200) begin
        fail_count++;
        test_done();
      end
    end
  endtask

  // Notes every expected phase, then runs one transfer and leaves two idle clocks.
  task automatic xfer(input logic w, input logic d, input logic [3:0] l);
    logic [31:0] a, wd, rdd;
    a = rnd();
    a[1:0] = 2'b00;
    wd = rnd();
    rdd = rnd();
    for (int k = 0; k <= int'(l); k++) begin
      if (w) begin
        wq.push_back({d, 1'b1, a + 32'(4 * k), wd, rdd[7:4]});
      end else begin
        rq.push_back(rdd);
      end
    end
    write_i = w;
    dual_i = d;
    addr_i = a;
    wdata_i = wd;
    be_n_i = rdd[7:4];
    len_i = l;
    rd_data_i = rdd;
    start_i = 1'b1;
    wait_busy(1'b1);
    start_i = 1'b0;
    wait_busy(1'b0);
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // Every completed write phase is compared with the note made when it was started.
  always @(posedge sys_clk_i) begin
    if (!reset_i) begin
      if (wr_valid_o === 1'b1) begin
        we = (wq.size() > 0) ? wq.pop_front() : 70'hX;
        wg = {we[69], cmd_o[0], wr_addr_o, wr_data_o, wr_be_n_o};
        chk_wr("write phase", we, wg);
      end
      if (rvalid_o === 1'b1) begin
        chk_rd("read word", (rq.size() > 0) ? rq.pop_front() : 32'hX, rdata_o);
      end
      chk_bit("parity error", 1'b0, dev_perr | host_perr);
    end
  end

  initial begin
    logic [31:0] r;
    reset_i = 1'b1;
    {grant_i, start_i, write_i, dual_i, addr_i, wdata_i, be_n_i, len_i} = '0;
    rd_data_i = 32'h0000_0000;
    repeat (3) @(posedge sys_clk_i);
    #1;
    reset_i = 1'b0;
    grant_i = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1;
    grant_i = 1'b0;
    start_i = 1'b1;
    repeat (4) begin
      @(posedge sys_clk_i);
      #1;
      chk_bit("busy without grant", 1'b0, busy_o);
    end
    start_i = 1'b0;
    grant_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    for (int m = 0; m < 4; m++) begin
      xfer(m[0], m[1], 4'hF);
    end
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      xfer(r[0], r[1], {2'b00, r[3:2]});
    end
    repeat (10) @(posedge sys_clk_i);
    #1;
    chk_bit("all phases seen", 1'b1, wq.size() == 0 && rq.size() == 0);
    test_done();
  end
endmodule
